// File: logic/adc_readout_pkg.sv
// Constants and types shared by the converter result readout logic
package adc_readout_pkg;
  // Serial framing
  localparam int CMD_BITS = 8;
  localparam int WORD_BITS = 24;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] WORD_LAST_BIT = 5'h17;
  localparam logic [7:0] EXIT_BYTE = 8'hff;
  localparam logic [7:0] NULL_BYTE = 8'h00;
  // Command byte fields
  localparam int CMD_TOP_POS = 7;
  localparam int CMD_PTR_LSB = 3;
  localparam logic [2:0] CAL_NONE = 3'h0;
  localparam int CAL_GAIN_POS = 1;
  // Setup table and result store
  localparam int SETUPS = 16;
  localparam int CHANNELS = 4;
  // Result word variant: 1 = 16-bit code plus status byte
  localparam logic RESULT_16BIT = 1'b1;
  // Status byte layout
  localparam int CI_LSB = 0;
  localparam int OF_POS = 2;
  localparam int OD_POS = 3;
  // Saturation limits of the filter output
  localparam logic signed [25:0] BI16_HI = 26'sd32767;
  localparam logic signed [25:0] BI16_LO = -26'sd32768;
  localparam logic signed [25:0] U16_HI = 26'sd65535;
  localparam logic signed [25:0] BI24_HI = 26'sd8388607;
  localparam logic signed [25:0] BI24_LO = -26'sd8388608;
  localparam logic signed [25:0] U24_HI = 26'sd16777215;
  localparam logic signed [25:0] UNI_LO = 26'sd0;
  // Serial port and conversion engine states
  typedef enum logic [1:0] {
    P_CMD = 2'b00,
    P_BUSY = 2'b01,
    P_FLAG = 2'b10,
    P_READ = 2'b11
  } port_state_e;
  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_REQ = 2'b01,
    E_WAIT = 2'b10
  } engine_state_e;
endpackage : adc_readout_pkg

// File: logic/serial_link_if.sv
// Synchronised serial clock edge and data bit between port modules
interface serial_link_if;
  logic sclk_rise;
  logic sdi_bit;
  modport source (output sclk_rise, output sdi_bit);
  modport sink (input sclk_rise, input sdi_bit);
endinterface : serial_link_if

// File: logic/serial_link_sync.sv
// Pin synchroniser and rising edge finder for the serial clock
module serial_link_sync
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic sdi_i,
  // Synchronised view
  serial_link_if.source link
);
  logic [2:0] sclk_reg;
  logic [2:0] sclk_next;
  logic [1:0] sdi_reg;
  logic [1:0] sdi_next;

  // Only the second and third stages feed the edge finder
  always_comb
  begin
    sclk_next = {sclk_reg[1:0], sclk_i};
    sdi_next = {sdi_reg[0], sdi_i};
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sclk_reg <= 3'h0;
      sdi_reg <= 2'h0;
    end
    else
    begin
      sclk_reg <= sclk_next;
      sdi_reg <= sdi_next;
    end
  end

  // SERIAL_DATA_IN is stable at the host's rising edge, so stage two is safe here
  assign link.sclk_rise = sclk_reg[1] & ~sclk_reg[2];
  assign link.sdi_bit = sdi_reg[1];
endmodule : serial_link_sync

// File: logic/adc_result_fifo_readout.sv
// Command decode, setup sequencing and result FIFO readout of the converter
//
// Contract
// - Multi-setup pass converts depth plus one setups
// - Data output falls when the set is done
// - Results leave in conversion order, three bytes each
// - Flag byte of ones exits, zeros keeps converting
// - Exit returns to command mode after FIFO drained
// - One offset and gain register per channel
// - Calibration keeps command mode, output falls when done
// - Pointer selects setup unless multi-setup selected
// - One command starts repeats over up to sixteen setups
// - Null command leaves port in command mode
// - FIFO words leave most significant bit first
// - Short variant: code in 23:8, status byte
// - Unipolar codes straight binary, saturating at limits
// - Bipolar codes two's complement, saturating at limits
// - Oscillation flag follows modulator oscillation detection
// - Overrange flag marks inputs beyond the span
// - Channel indicator encodes converted physical channel
// - Wait mode stalls until the set is read
module adc_result_fifo_readout
  import adc_readout_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Serial port pins
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic serial_data_out_o,
  // Configuration
  input wire logic [3:0] setup_depth_field_i,
  input wire logic multi_setup_select_i,
  input wire logic repeat_loop_select_i,
  input wire logic wait_for_read_select_i,
  input wire logic bipolar_i,
  input wire logic [2*SETUPS-1:0] setup_channel_i,
  // Conversion front end
  output logic conv_req_o,
  output logic [3:0] conv_setup_o,
  output logic [1:0] conv_channel_o,
  input wire logic conv_done_i,
  input wire logic signed [25:0] raw_value_i,
  input wire logic osc_detect_i,
  // Calibration front end
  output logic cal_req_o,
  output logic [2:0] cal_type_o,
  input wire logic cal_done_i,
  input wire logic [23:0] cal_value_i,
  // Correction values and status
  output logic [23:0] chan_offset_o,
  output logic [23:0] chan_gain_o,
  output logic overrange_flag_o,
  output logic oscillation_flag_o
);
  serial_link_if link ();

  serial_link_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sclk_i(sclk_i),
    .sdi_i(sdi_i),
    .link(link)
  );

  // Result store and per-channel calibration registers
  logic [WORD_BITS-1:0] fifo_mem [SETUPS];
  logic [23:0] offset_mem [CHANNELS];
  logic [23:0] gain_mem [CHANNELS];

  port_state_e port_reg, port_next;
  engine_state_e eng_reg, eng_next;
  logic [7:0] rx_reg, rx_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [4:0] word_idx_reg, word_idx_next;
  logic [WORD_BITS-1:0] tx_reg, tx_next;
  logic [3:0] ptr_reg, ptr_next;
  logic exit_reg, exit_next, repeat_reg, repeat_next;
  logic wait_reg, wait_next, ready_reg, ready_next;
  logic cal_low_reg, cal_low_next, cal_busy_reg, cal_busy_next;
  logic cal_req_reg, cal_req_next, sdo_reg, sdo_next;
  logic [2:0] cal_type_reg, cal_type_next;
  logic [1:0] cal_ch_reg, cal_ch_next, ch_reg, ch_next;
  logic [3:0] setup_reg, setup_next, wptr_reg, wptr_next;
  logic [4:0] set_len_reg, set_len_next;
  logic of_reg, of_next, od_reg;
  logic start_conv, set_done, fifo_we;
  logic [7:0] byte_w;
  logic [24:0] clamp_w;
  logic [WORD_BITS-1:0] word_w;

  // Saturate the filter output; bit 24 reports the clamp as overrange
  function automatic logic [24:0] clamp_code(
    input logic signed [25:0] raw, input logic bip);
    logic signed [25:0] hi, lo;
    hi = bip ? (RESULT_16BIT ? BI16_HI : BI24_HI)
             : (RESULT_16BIT ? U16_HI : U24_HI);
    lo = bip ? (RESULT_16BIT ? BI16_LO : BI24_LO) : UNI_LO;
    if (raw > hi)
      clamp_code = {1'b1, hi[23:0]};
    else if (raw < lo)
      clamp_code = {1'b1, lo[23:0]};
    else
      clamp_code = {1'b0, raw[23:0]};
  endfunction : clamp_code

  // Result word packing with the status byte in the short variant
  always_comb
  begin
    clamp_w = clamp_code(raw_value_i, bipolar_i);
    word_w = clamp_w[23:0];
    if (RESULT_16BIT)
    begin
      word_w = {clamp_w[15:0], 8'h00};
      word_w[CI_LSB +: 2] = ch_reg;
      word_w[OF_POS] = clamp_w[24];
      word_w[OD_POS] = osc_detect_i;
    end
  end

  assign byte_w = {rx_reg[6:0], link.sdi_bit};
  assign fifo_we = (eng_reg == E_WAIT) && conv_done_i;

  // Conversion engine walks the setups of one pass
  always_comb
  begin
    eng_next = eng_reg;
    setup_next = setup_reg;
    wptr_next = wptr_reg;
    set_len_next = set_len_reg;
    ch_next = ch_reg;
    of_next = of_reg;
    set_done = 1'b0;
    case (eng_reg)
      E_IDLE:
      begin
        if (start_conv)
        begin
          // Stored order from setup 0, or the command's pointer
          setup_next = multi_setup_select_i ? 4'h0 : ptr_next;
          set_len_next = multi_setup_select_i
            ? {1'b0, setup_depth_field_i} + 5'h01 : 5'h01;
          wptr_next = 4'h0;
          eng_next = E_REQ;
        end
      end
      E_REQ:
      begin
        ch_next = setup_channel_i[2*setup_reg +: 2];
        eng_next = E_WAIT;
      end
      E_WAIT:
      begin
        if (conv_done_i)
        begin
          of_next = clamp_w[24];
          if ({1'b0, wptr_reg} + 5'h01 == set_len_reg)
          begin
            set_done = 1'b1;
            eng_next = E_IDLE;
          end
          else
          begin
            wptr_next = wptr_reg + 4'h1;
            setup_next = setup_reg + 4'h1;
            eng_next = E_REQ;
          end
        end
      end
      default: eng_next = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      eng_reg <= E_IDLE;
      setup_reg <= 4'h0;
      wptr_reg <= 4'h0;
      set_len_reg <= 5'h01;
      ch_reg <= 2'h0;
      of_reg <= 1'b0;
      od_reg <= 1'b0;
    end
    else
    begin
      eng_reg <= eng_next;
      setup_reg <= setup_next;
      wptr_reg <= wptr_next;
      set_len_reg <= set_len_next;
      ch_reg <= ch_next;
      of_reg <= of_next;
      od_reg <= osc_detect_i;
    end
  end

  // Serial port: command byte, flag byte and result shifting
  always_comb
  begin
    port_next = port_reg;
    rx_next = rx_reg;
    bit_cnt_next = bit_cnt_reg;
    word_idx_next = word_idx_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    exit_next = exit_reg;
    repeat_next = repeat_reg;
    wait_next = wait_reg;
    cal_busy_next = cal_busy_reg;
    cal_req_next = 1'b0;
    cal_type_next = cal_type_reg;
    cal_ch_next = cal_ch_reg;
    start_conv = 1'b0;
    if (link.sclk_rise && port_reg != P_BUSY)
    begin
      rx_next = byte_w;
      bit_cnt_next = bit_cnt_reg + 5'h01;
    end
    case (port_reg)
      P_CMD:
      begin
        if (link.sclk_rise && bit_cnt_reg == CMD_LAST_BIT)
        begin
          bit_cnt_next = 5'h00;
          // Top bit clear, null byte included, leaves the port idle
          if (byte_w[CMD_TOP_POS] && !cal_busy_reg)
          begin
            ptr_next = byte_w[CMD_PTR_LSB +: 4];
            if (byte_w[2:0] == CAL_NONE)
            begin
              start_conv = 1'b1;
              repeat_next = repeat_loop_select_i;
              wait_next = wait_for_read_select_i;
              port_next = P_BUSY;
            end
            else
            begin
              cal_req_next = 1'b1;
              cal_busy_next = 1'b1;
              cal_type_next = byte_w[2:0];
              cal_ch_next = setup_channel_i[2*ptr_next +: 2];
            end
          end
        end
        if (cal_done_i)
          cal_busy_next = 1'b0;
      end
      P_BUSY:
      begin
        // Port parks here until the engine reports the set done
        if (ready_reg)
        begin
          bit_cnt_next = 5'h00;
          port_next = P_FLAG;
        end
      end
      P_FLAG:
      begin
        if (link.sclk_rise && bit_cnt_reg == CMD_LAST_BIT)
        begin
          exit_next = (byte_w == EXIT_BYTE) || !repeat_reg;
          bit_cnt_next = 5'h00;
          word_idx_next = 5'h00;
          tx_next = fifo_mem[0];
          port_next = P_READ;
          // No-wait mode refills the FIFO while the host reads
          start_conv = repeat_reg && (byte_w != EXIT_BYTE)
                       && !wait_reg;
        end
      end
      P_READ:
      begin
        if (link.sclk_rise)
        begin
          tx_next = {tx_reg[WORD_BITS-2:0], 1'b0};
          if (bit_cnt_reg == WORD_LAST_BIT)
          begin
            bit_cnt_next = 5'h00;
            if (word_idx_reg + 5'h01 == set_len_reg)
            begin
              port_next = exit_reg ? P_CMD : P_BUSY;
              start_conv = !exit_reg && wait_reg;
            end
            else
            begin
              word_idx_next = word_idx_reg + 5'h01;
              tx_next = fifo_mem[word_idx_next[3:0]];
            end
          end
        end
      end
      default: port_next = P_CMD;
    endcase
    // Completion wins over the clear of the same cycle
    ready_next = (ready_reg && !(port_reg == P_BUSY)) || set_done;
    cal_low_next = (cal_low_reg && !(link.sclk_rise && port_reg == P_CMD))
                   || cal_done_i;
    case (port_next)
      P_CMD: sdo_next = !cal_low_next;
      P_FLAG: sdo_next = 1'b0;
      P_READ: sdo_next = tx_next[WORD_BITS-1];
      default: sdo_next = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      port_reg <= P_CMD;
      rx_reg <= 8'h00;
      bit_cnt_reg <= 5'h00;
      word_idx_reg <= 5'h00;
      tx_reg <= 24'h000000;
      ptr_reg <= 4'h0;
      exit_reg <= 1'b1;
      repeat_reg <= 1'b0;
      wait_reg <= 1'b0;
      ready_reg <= 1'b0;
      cal_low_reg <= 1'b0;
      cal_busy_reg <= 1'b0;
      cal_req_reg <= 1'b0;
      cal_type_reg <= 3'h0;
      cal_ch_reg <= 2'h0;
      sdo_reg <= 1'b1;
    end
    else
    begin
      port_reg <= port_next;
      rx_reg <= rx_next;
      bit_cnt_reg <= bit_cnt_next;
      word_idx_reg <= word_idx_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      exit_reg <= exit_next;
      repeat_reg <= repeat_next;
      wait_reg <= wait_next;
      ready_reg <= ready_next;
      cal_low_reg <= cal_low_next;
      cal_busy_reg <= cal_busy_next;
      cal_req_reg <= cal_req_next;
      cal_type_reg <= cal_type_next;
      cal_ch_reg <= cal_ch_next;
      sdo_reg <= sdo_next;
    end
  end

  // Storage; a later calibration of a channel replaces the earlier one
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < SETUPS; i++)
        fifo_mem[i] <= 24'h000000;
      for (int c = 0; c < CHANNELS; c++)
      begin
        offset_mem[c] <= 24'h000000;
        gain_mem[c] <= 24'h000000;
      end
    end
    else
    begin
      if (fifo_we)
        fifo_mem[wptr_reg] <= word_w;
      if (cal_done_i && cal_type_reg[CAL_GAIN_POS])
        gain_mem[cal_ch_reg] <= cal_value_i;
      else if (cal_done_i)
        offset_mem[cal_ch_reg] <= cal_value_i;
    end
  end

  assign serial_data_out_o = sdo_reg;
  assign conv_req_o = (eng_reg == E_REQ);
  assign conv_setup_o = setup_reg;
  assign conv_channel_o = ch_reg;
  assign cal_req_o = cal_req_reg;
  assign cal_type_o = cal_type_reg;
  assign chan_offset_o = offset_mem[ch_reg];
  assign chan_gain_o = gain_mem[ch_reg];
  assign overrange_flag_o = of_reg;
  assign oscillation_flag_o = od_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  depth_count_a: assert property (start_conv && eng_reg == E_IDLE && multi_setup_select_i |=> set_len_reg == {1'b0, $past(setup_depth_field_i)} + 5'h01 && setup_reg == 4'h0) else $error("pass length or first setup wrong");
  sdo_ready_a: assert property (port_reg == P_BUSY && ready_reg |=> ##[0:1] !serial_data_out_o) else $error("data output did not fall");
  flag_byte_a: assert property (port_reg == P_FLAG && link.sclk_rise && bit_cnt_reg == CMD_LAST_BIT |=> port_reg == P_READ && tx_reg == fifo_mem[0]) else $error("flag byte did not open readout");
  exit_done_a: assert property (port_reg == P_READ && link.sclk_rise && bit_cnt_reg == WORD_LAST_BIT && word_idx_reg + 5'h01 == set_len_reg && exit_reg |=> port_reg == P_CMD ##1 serial_data_out_o || cal_low_reg) else $error("exit did not reach command mode");
  wait_stall_a: assert property (port_reg == P_READ && link.sclk_rise && bit_cnt_reg == WORD_LAST_BIT && word_idx_reg + 5'h01 == set_len_reg && !exit_reg && wait_reg |=> eng_reg == E_REQ && port_reg == P_BUSY) else $error("wait mode did not restart");
  ptr_select_a: assert property (start_conv && port_reg == P_CMD && !multi_setup_select_i |=> conv_req_o && conv_setup_o == $past(byte_w[6:3])) else $error("pointer not used");
  null_cmd_a: assert property (port_reg == P_CMD && link.sclk_rise && bit_cnt_reg == CMD_LAST_BIT && byte_w == NULL_BYTE |=> port_reg == P_CMD && !cal_req_o && eng_reg == E_IDLE) else $error("null command acted");
  cal_cmd_a: assert property (cal_req_o |-> port_reg == P_CMD && cal_type_o != CAL_NONE) else $error("calibration left command mode");
  cal_store_a: assert property (cal_done_i && !cal_type_reg[CAL_GAIN_POS] |=> offset_mem[$past(cal_ch_reg)] == $past(cal_value_i)) else $error("offset not stored");
  bip_sat_a: assert property (fifo_we && bipolar_i && raw_value_i > BI16_HI |-> word_w[23:8] == 16'h7fff && word_w[OF_POS]) else $error("bipolar clamp wrong");
  uni_sat_a: assert property (fifo_we && !bipolar_i && raw_value_i < UNI_LO |-> word_w[23:8] == 16'h0000 && word_w[OF_POS]) else $error("unipolar clamp wrong");

  repeat_exit_c: cover property (port_reg == P_FLAG && link.sclk_rise && bit_cnt_reg == CMD_LAST_BIT && byte_w == EXIT_BYTE && repeat_reg);
  background_c: cover property (port_reg == P_READ && eng_reg == E_WAIT);
  cal_done_c: cover property (cal_done_i ##1 !serial_data_out_o);
  ten_setups_c: cover property (set_done && set_len_reg == 5'h0a);
endmodule : adc_result_fifo_readout

// File: sim/host_model.sv
// Host side of the three-wire serial port, driving the serial clock
module host_model
(
  // Clock
  input wire logic clk_i,
  // Serial pins
  input wire logic serial_data_out_i,
  output logic sclk_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Serial clock stands low between frames
  initial
  begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // One clock: data set in the low phase, output sampled just before rise
  task automatic bit_xfer(input logic d, output logic q);
    @(posedge clk_i);
    #1;
    sdi_o = d;
    // Four system clocks low and four high give the 80 ns serial period
    repeat (3) @(posedge clk_i);
    #1;
    q = serial_data_out_i;
    sclk_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    sclk_o = 1'b0;
  endtask : bit_xfer

  // Command or flag byte, top bit first
  task automatic send_byte(input logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], q);
  endtask : send_byte

  // Whole 24-clock word; input toggles since the port ignores it here
  task automatic read_word(output logic [23:0] w);
    logic q;
    for (int i = 23; i >= 0; i--)
    begin
      bit_xfer(i[0], q);
      w[i] = q;
    end
  endtask : read_word
endmodule : host_model

// File: sim/tb.sv
// Self-checking bench for the converter result readout
module tb
  import adc_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i, reset_n_i, sclk, serial_data_in, serial_data_out;
  logic [3:0] depth, conv_setup, last_setup;
  logic mc, lp, rc, bip, conv_req, conv_done, osc, cal_req, cal_done;
  logic [2*SETUPS-1:0] setup_ch;
  logic [1:0] conv_channel;
  logic signed [25:0] raw_value;
  logic [2:0] cal_type, last_cal_type;
  logic [23:0] cal_value, chan_offset, chan_gain, last_offset, cal_val;
  logic [23:0] last_gain;
  logic of_flag, od_flag;
  int fail_count, tests_run, req_count, cal_count, conv_delay;

  adc_result_fifo_readout u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .sclk_i(sclk), .sdi_i(serial_data_in), .serial_data_out_o(serial_data_out),
    .setup_depth_field_i(depth), .multi_setup_select_i(mc),
    .repeat_loop_select_i(lp), .wait_for_read_select_i(rc),
    .bipolar_i(bip), .setup_channel_i(setup_ch), .conv_req_o(conv_req),
    .conv_setup_o(conv_setup), .conv_channel_o(conv_channel),
    .conv_done_i(conv_done), .raw_value_i(raw_value), .osc_detect_i(osc),
    .cal_req_o(cal_req), .cal_type_o(cal_type), .cal_done_i(cal_done),
    .cal_value_i(cal_value), .chan_offset_o(chan_offset),
    .chan_gain_o(chan_gain), .overrange_flag_o(of_flag),
    .oscillation_flag_o(od_flag));

  host_model u_host (.clk_i(clk_i), .serial_data_out_i(serial_data_out),
    .sclk_o(sclk), .sdi_o(serial_data_in));

  // Stimulus tables: channel and filter value of each setup
  function automatic logic [1:0] ch_of(input int k);
    return 2'((k * 3 + 1) % 4);
  endfunction : ch_of

  function automatic int raw_of(input int k);
    return (k == 0) ? -40000 : (k == 1) ? 40000 : (k == 5) ? 70000 :
      k * 1000 - 3000;
  endfunction : raw_of

  // Expected word: clamped 16-bit code, then the status byte
  function automatic logic [23:0] exp_word(input int k, input logic b);
    int r, hi, lo;
    logic ov;
    r = raw_of(k);
    hi = b ? 32767 : 65535;
    lo = b ? -32768 : 0;
    ov = (r > hi) || (r < lo);
    r = (r > hi) ? hi : ((r < lo) ? lo : r);
    return {r[15:0], 4'h0, k == 3, ov, ch_of(k)};
  endfunction : exp_word

  task automatic check_word(input logic [23:0] got, input logic [23:0] exp,
    input string msg);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : check_bit

  // Bounded wait for the data output to fall
  task automatic wait_ready(input int limit);
    int n;
    n = 0;
    while (serial_data_out !== 1'b0 && n < limit)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check_bit(serial_data_out, 1'b0, "ready flag");
  endtask : wait_ready

  task automatic t_null();
    int n0;
    n0 = req_count + cal_count;
    u_host.send_byte(NULL_BYTE);
    repeat (40) @(posedge clk_i);
    #1;
    check_bit(serial_data_out, 1'b1, "null command output");
    check_word(24'(req_count + cal_count - n0), 24'h0, "null work");
    $display("test null command done");
  endtask : t_null

  task automatic t_single();
    logic [23:0] w;
    mc = 1'b0;
    lp = 1'b0;
    bip = 1'b0;
    u_host.send_byte(8'ha8);
    wait_ready(2000);
    check_word(24'(last_setup), 24'h5, "pointer setup");
    u_host.send_byte(NULL_BYTE);
    u_host.read_word(w);
    check_word(w, exp_word(5, 1'b0), "single word");
    check_word(w, 24'hffff04, "unipolar limit");
    repeat (10) @(posedge clk_i);
    #1;
    check_bit(serial_data_out, 1'b1, "single back to command");
    // A further single conversion needs a command byte of its own
    u_host.send_byte(8'h80);
    wait_ready(2000);
    u_host.send_byte(NULL_BYTE);
    u_host.read_word(w);
    check_word(w, 24'h000005, "unipolar floor");
    check_bit(serial_data_out, 1'b1, "second single back to command");
    $display("test single conversion done");
  endtask : t_single

  task automatic t_multi(input logic ws, input logic [3:0] dep, input int dly);
    logic [23:0] w;
    int n0;
    conv_delay = dly;
    depth = dep;
    mc = 1'b1;
    lp = 1'b1;
    rc = ws;
    bip = 1'b1;
    u_host.send_byte(8'h80);
    for (int p = 0; p < 2; p++)
    begin
      wait_ready((int'(dep) + 1) * (dly + 20) + 500);
      u_host.send_byte(p == 1 ? EXIT_BYTE : NULL_BYTE);
      n0 = req_count;
      for (int k = 0; k <= int'(dep); k++)
      begin
        u_host.read_word(w);
        check_word(w, exp_word(k, 1'b1), "pass word");
      end
      // Wait mode restarts only as the last bit of the set goes out
      if (ws == 1'b1)
        check_word(24'(req_count - n0), 24'(p == 0), "wait stall");
    end
    n0 = req_count;
    repeat (100) @(posedge clk_i);
    #1;
    check_bit(serial_data_out, 1'b1, "exit to command");
    check_word(24'(req_count - n0), 24'h0, "work after exit");
    $display("test repeated multi-setup done");
  endtask : t_multi

  task automatic t_cal();
    logic [23:0] w;
    conv_delay = 5;
    cal_val = 24'h0a0b0c;
    u_host.send_byte(8'had);
    wait_ready(500);
    check_word(24'(last_cal_type), 24'h5, "calibration type");
    cal_val = 24'h123456;
    u_host.send_byte(8'hcd);
    wait_ready(500);
    cal_val = 24'h654321;
    u_host.send_byte(8'hae);
    wait_ready(500);
    check_word(24'(last_cal_type), 24'h6, "gain calibration type");
    mc = 1'b0;
    lp = 1'b0;
    bip = 1'b0;
    u_host.send_byte(8'ha8);
    wait_ready(2000);
    check_word(last_offset, 24'h123456, "shared channel offset");
    check_word(last_gain, 24'h654321, "shared channel gain");
    u_host.send_byte(NULL_BYTE);
    u_host.read_word(w);
    check_word(w, 24'hffff04, "word after calibration");
    $display("test calibration done");
  endtask : t_cal

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // System clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Front end: answers conversion and calibration requests after a delay;
  // a request that follows a done at once is seen without a lost cycle
  initial
  begin
    logic [23:0] ew;
    logic [1:0] ech;
    @(posedge clk_i);
    #1;
    forever
    begin
      if (conv_req === 1'b1)
      begin
        req_count++;
        last_setup = conv_setup;
        osc = (conv_setup == 4'h3);
        repeat (conv_delay) @(posedge clk_i);
        #1;
        raw_value = 26'(raw_of(int'(last_setup)));
        last_offset = chan_offset;
        last_gain = chan_gain;
        ech = ch_of(int'(last_setup));
        check_word(24'(conv_channel), 24'(ech), "setup channel");
        conv_done = 1'b1;
        @(posedge clk_i);
        #1;
        conv_done = 1'b0;
        ew = exp_word(int'(last_setup), bip);
        check_bit(of_flag, ew[2], "overrange flag");
        check_bit(od_flag, ew[3], "oscillation flag");
      end
      else if (cal_req === 1'b1)
      begin
        cal_count++;
        last_cal_type = cal_type;
        repeat (20) @(posedge clk_i);
        #1;
        cal_value = cal_val;
        cal_done = 1'b1;
        @(posedge clk_i);
        #1;
        cal_done = 1'b0;
      end
      else
      begin
        @(posedge clk_i);
        #1;
      end
    end
  end

  // Watchdog against a hung handshake
  initial
  begin
    #800000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  // Main sequence
  initial
  begin
    {depth, mc, lp, rc, bip, conv_done, osc, cal_done} = '0;
    {raw_value, cal_value, cal_val, last_offset, last_gain} = '0;
    {last_setup, last_cal_type} = '0;
    {fail_count, tests_run, req_count, cal_count} = '0;
    conv_delay = 5;
    for (int k = 0; k < SETUPS; k++)
      setup_ch[2*k +: 2] = ch_of(k);
    reset_n_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    check_bit(serial_data_out, 1'b1, "idle after reset");
    t_null();
    t_single();
    t_multi(1'b0, 4'h9, 300);
    t_multi(1'b1, 4'hf, 5);
    t_cal();
    results();
  end
endmodule : tb
